// file: logic/uhie_top.sv
// Chosen here: the APB interface to the registers.
module uhie_top
   import uhie_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] event_in,
   output logic irq
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [31:0] en_q; // Enable mask, master at bit 31
   logic [31:0] en_d; // Next enable mask
   logic [31:0] flag_q; // Latched event flags
   logic [31:0] flag_clr; // Software clear strobes for the flags
   logic [31:0] prdata_q; // Registered read data
   logic [31:0] prdata_d; // Next read data
   logic pslverr_q; // Registered error answer
   logic pslverr_d; // Next error answer
   logic irq_q; // Registered interrupt request
   logic irq_d; // Next interrupt request
   logic pready_q; // Registered ready answer
   logic pready_d; // Next ready answer
   logic setup; // Setup phase of a transfer
   logic wr_set; // Setup write to the set location
   logic wr_clr; // Setup write to the clear location
   logic wr_flag; // Setup write to the flag location
   logic hit; // Address is one of ours

   // ****************************************
   // Bus decode
   // ****************************************
   // Work is done in the setup cycle so the answer is registered
   // and ready by the access phase; every access takes two cycles.
   assign setup = psel && !penable;
   assign hit = (paddr == UHIE_ADDR_SET) || (paddr == UHIE_ADDR_CLEAR)
      || (paddr == UHIE_ADDR_FLAGS);
   assign wr_set = setup && pwrite && (paddr == UHIE_ADDR_SET);
   assign wr_clr = setup && pwrite && (paddr == UHIE_ADDR_CLEAR);
   assign wr_flag = setup && pwrite && (paddr == UHIE_ADDR_FLAGS);

   // ****************************************
   // Enable mask
   // ****************************************
   // Only implemented bits are touched; bit 4 and reserved stay zero
   always_comb begin
      en_d = en_q;
      if (wr_set) begin
         en_d = en_q | (pwdata & UHIE_EN_MASK);
      end
      if (wr_clr) begin
         en_d = en_q & ~(pwdata & UHIE_EN_MASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= UHIE_EN_RESET;
      end else if (ce) begin
         en_q <= en_d;
      end
   end

   // ****************************************
   // Event flags
   // ****************************************
   // Writing one to a flag location bit clears that flag
   assign flag_clr = wr_flag ? pwdata : 32'h00000000;

   // One flag per implemented source; others tie to zero
   for (genvar i = 0; i < 32; i++) begin : g_flag
      if (UHIE_SRC_MASK[i]) begin : g_impl
         uhie_flag_bit u_flag (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .evt(event_in[i]),
            .clr(flag_clr[i]),
            .flag_q(flag_q[i])
         );
      end else begin : g_none
         assign flag_q[i] = 1'b0;
      end
   end

   // ****************************************
   // Interrupt request
   // ****************************************
   // Each source gated by its own enable, all gated by the master
   always_comb begin
      irq_d = en_q[UHIE_BIT_MASTER]
         && |(flag_q & en_q & UHIE_SRC_MASK);
      // Per-source gating above also
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= irq_d;
      end
   end

   // ****************************************
   // Read data and answer
   // ****************************************
   // Unmapped addresses answer with pslverr and zero data
   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      if (setup) begin
         pslverr_d = !hit;
         prdata_d = 32'h00000000;
         if (!pwrite) begin
            if ((paddr == UHIE_ADDR_SET) || (paddr == UHIE_ADDR_CLEAR)) begin
               prdata_d = en_q & UHIE_EN_MASK;
            end else if (paddr == UHIE_ADDR_FLAGS) begin
               prdata_d = flag_q;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= UHIE_RDATA_RESET;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

   // ****************************************
   // Ready answer
   // ****************************************
   // Always ready: the answer was prepared in the setup cycle.
   // Kept in a flop so every output leaves from a register;
   // it resets high so a transfer right after reset still ends.
   always_comb begin
      pready_d = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b1;
      end else if (ce) begin
         pready_q <= pready_d;
      end
   end

   assign pready = pready_q;

   // ****************************************
   // Timing notes
   // ****************************************
   // A transfer is taken at the setup edge (psel high, penable low).
   // A write lands in the mask or clears flags at that edge.
   // A read loads prdata at that edge; it stands through the access
   // phase and until the next setup cycle.
   // The interrupt request follows the mask one edge later, so a
   // write that enables a pending source shows on irq at the access
   // edge of that same transfer.
   // A low clock enable freezes every register: a transfer whose
   // setup edge sees it low is lost; software must keep it high.
   // Limitation: events arriving while the enable is low are lost.

   // ****************************************
   // Checks
   // ****************************************
   chk_set_bits: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_set) |=> ((en_q & $past(pwdata) & UHIE_EN_MASK)
         == ($past(pwdata) & UHIE_EN_MASK)))
      else $error("set write did not set mask bits");
   chk_clear_bits: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_clr) |=> ((en_q & $past(pwdata) & UHIE_EN_MASK) == 32'h00000000))
      else $error("clear write did not clear mask bits");
   chk_keep_unwritten: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_set) |=> ((en_q & ~$past(pwdata)) == ($past(en_q) & ~$past(pwdata))))
      else $error("set write disturbed other bits");
   chk_master_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && !en_q[UHIE_BIT_MASTER]) |=> !irq)
      else $error("irq raised without master enable");
   chk_irq_cause: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> (irq == ($past(en_q[UHIE_BIT_MASTER])
         && (|($past(flag_q) & $past(en_q) & UHIE_SRC_MASK)))))
      else $error("irq does not follow enabled flags");
   chk_fatal_zero: assert property (@(posedge pclk) disable iff (!presetn)
      en_q[UHIE_BIT_FATAL] == 1'b0)
      else $error("unimplemented enable bit became set");
   chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (en_q & ~UHIE_EN_MASK) == 32'h00000000)
      else $error("reserved mask bits not zero");
   chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && event_in[UHIE_BIT_SOF]) |=> flag_q[UHIE_BIT_SOF])
      else $error("event flag not held");
   chk_read_mask: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && !pwrite && paddr == UHIE_ADDR_CLEAR) |=> prdata == $past(en_q))
      else $error("read of clear location wrong");

   // ****************************************
   // Checks on the bus answer
   // ****************************************
   // The set location reads the same mask as the clear location
   chk_read_set: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && !pwrite && paddr == UHIE_ADDR_SET) |=> prdata == $past(en_q))
      else $error("read of set location wrong");

   // Flag location reads the latched flags as they stood at setup
   chk_read_flags: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && !pwrite && paddr == UHIE_ADDR_FLAGS) |=> prdata == $past(flag_q))
      else $error("read of flag location wrong");

   // Unmapped words answer with an error
   chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && !hit) |=> pslverr)
      else $error("unmapped access gave no error");

   // Mapped words never answer with an error
   chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && hit) |=> !pslverr)
      else $error("mapped access gave an error");

   // No wait states: the access phase always completes
   chk_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
      pready)
      else $error("ready answer dropped");

   // ****************************************
   // Checks on the enable mask
   // ****************************************
   // Zeros written to the clear location leave their bits alone
   chk_clear_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_clr) |=> ((en_q & ~$past(pwdata)) == ($past(en_q) & ~$past(pwdata))))
      else $error("clear write disturbed other bits");

   // Master enable comes on through the set location
   chk_master_set: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_set && pwdata[UHIE_BIT_MASTER]) |=> en_q[UHIE_BIT_MASTER])
      else $error("master enable not set");

   // Master enable goes off through the clear location
   chk_master_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_clr && pwdata[UHIE_BIT_MASTER]) |=> !en_q[UHIE_BIT_MASTER])
      else $error("master enable not cleared");

   // ****************************************
   // Checks on the event flags
   // ****************************************
   // A clear with no event in the same cycle drops the flag
   chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_flag && pwdata[UHIE_BIT_SOF] && !event_in[UHIE_BIT_SOF])
      |=> !flag_q[UHIE_BIT_SOF])
      else $error("event flag not cleared");

   // An event in the clear cycle wins so no event is lost
   chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && wr_flag && pwdata[UHIE_BIT_SOF] && event_in[UHIE_BIT_SOF])
      |=> flag_q[UHIE_BIT_SOF])
      else $error("event lost against a clear");

   // Flags exist only at implemented source positions
   chk_flag_places: assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q & ~UHIE_SRC_MASK) == 32'h00000000)
      else $error("flag outside a source position");

   // ****************************************
   // Checks on the clock enable
   // ****************************************
   // A low enable holds the mask
   chk_freeze_mask: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> en_q == $past(en_q))
      else $error("mask moved while frozen");

   // A low enable holds the flags
   chk_freeze_flags: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> flag_q == $past(flag_q))
      else $error("flags moved while frozen");

   // A low enable holds the request
   chk_freeze_irq: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> irq == $past(irq))
      else $error("irq moved while frozen");

   // A low enable holds the read data
   chk_freeze_read: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> prdata == $past(prdata))
      else $error("read data moved while frozen");

   // ****************************************
   // Per-source gating
   // ****************************************
   // A lone pending flag whose own enable is off never raises irq
   for (genvar s = 0; s < 32; s++) begin : g_src_chk
      if (UHIE_SRC_MASK[s]) begin : g_on
         chk_src_gate: assert property (@(posedge pclk) disable iff (!presetn)
            (ce && !en_q[s] && flag_q == (32'h00000001 << s)) |=> !irq)
            else $error("disabled source raised irq");
      end
   end
   // The loop above carries
endmodule : uhie_top

// file: logic/uhie_pkg.sv
package uhie_pkg;
   // ****************************************
   // Register map
   // ****************************************
   // Status flags live at the event flag location
   localparam logic [31:0] UHIE_ADDR_FLAGS = 32'hfff0500c;
   // Enable mask set location, write one to set
   localparam logic [31:0] UHIE_ADDR_SET = 32'hfff05010;
   // Enable mask clear location, write one to clear
   localparam logic [31:0] UHIE_ADDR_CLEAR = 32'hfff05014;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int UHIE_BIT_MASTER = 31;
   localparam int UHIE_BIT_OWNER = 30;
   localparam int UHIE_BIT_ROOT = 6;
   localparam int UHIE_BIT_FWRAP = 5;
   localparam int UHIE_BIT_FATAL = 4;
   localparam int UHIE_BIT_WAKE = 3;
   localparam int UHIE_BIT_SOF = 2;
   localparam int UHIE_BIT_DONE = 1;
   localparam int UHIE_BIT_OVRN = 0;

   // Source enable bits that exist (30, 6, 5, 3, 2, 1, 0)
   localparam logic [31:0] UHIE_SRC_MASK = 32'h4000006f;
   // Writable bits of the enable location, master included
   localparam logic [31:0] UHIE_EN_MASK = 32'hc000006f;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [31:0] UHIE_EN_RESET = 32'h00000000;
   localparam logic [31:0] UHIE_FLAG_RESET = 32'h00000000;
   localparam logic [31:0] UHIE_RDATA_RESET = 32'h00000000;
endpackage : uhie_pkg

// file: logic/uhie_flag_bit.sv
// One sticky event flag: hardware sets, software clears, set wins
module uhie_flag_bit
   import uhie_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic evt,
   input wire logic clr,
   output logic flag_q
);
   logic flag_d; // Next flag value

   // ****************************************
   // Next value
   // ****************************************
   // A set in the same cycle as a clear survives so no event is lost
   always_comb begin
      flag_d = flag_q;
      if (clr) begin
         flag_d = 1'b0;
      end
      if (evt) begin
         flag_d = 1'b1;
      end
   end

   // ****************************************
   // Register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (ce) begin
         flag_q <= flag_d;
      end
   end
endmodule : uhie_flag_bit

// file: tb/usb_host_irq_enable_mask_bench.sv
module usb_host_irq_enable_mask_bench import uhie_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // Bench signals
   // ****************************************
   logic pclk;
   logic presetn;
   logic ce;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] event_in;
   logic irq;
   logic [31:0] rd; // Data taken at the access edge
   logic slv; // Error answer taken at the access edge
   int err_total;
   int cmp_count;
   // Implemented sources, master excluded
   int src [7] = '{30, 6, 5, 3, 2, 1, 0};

   uhie_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_in(event_in), .irq(irq));

   // Free running 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   // Compare and count; four-state equality keeps unknowns from matching
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One APB transfer; entered just after a rising edge, leaves one idle edge
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait on a stuck slave
      while (pready !== 1'b1) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Look at the request away from the edge, where it has settled
   task automatic irq_is(input logic exp);
      @(negedge pclk);
      check("irq", {31'h0, irq}, {31'h0, exp});
      @(posedge pclk);
   endtask : irq_is

   // Verdict; also reached from the watchdog
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      err_total = 0;
      cmp_count = 0;
      presetn = 1'b0;
      ce = 1'b1; // Held high except for the one frozen write below
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      event_in = 32'h00000000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      irq_is(1'b0);
      apb(1'b0, UHIE_ADDR_SET, 32'h0);
      check("mask after reset", rd, 32'h00000000);
      $display("test reset done");
      // Set everything: only implemented bits may stick, bit 4 stays clear
      apb(1'b1, UHIE_ADDR_SET, 32'hffffffff);
      apb(1'b0, UHIE_ADDR_SET, 32'h0);
      check("mask via set", rd, 32'hc000006f);
      check("mapped error", {31'h0, slv}, 32'h0);
      apb(1'b0, UHIE_ADDR_CLEAR, 32'h0);
      check("mask via clear", rd, 32'hc000006f);
      // Clear a few bits; zeros must leave the rest alone
      apb(1'b1, UHIE_ADDR_CLEAR, 32'h40000050);
      apb(1'b0, UHIE_ADDR_SET, 32'h0);
      check("mask after clear", rd, 32'h8000002f);
      apb(1'b1, UHIE_ADDR_SET, 32'h00000010);
      apb(1'b0, UHIE_ADDR_CLEAR, 32'h0);
      check("bit4 ignored", rd, 32'h8000002f);
      // A write whose setup edge sees the enable low is lost
      ce <= 1'b0;
      apb(1'b1, UHIE_ADDR_SET, 32'h00000040);
      ce <= 1'b1;
      apb(1'b0, UHIE_ADDR_SET, 32'h0);
      check("frozen write", rd, 32'h8000002f);
      // Unmapped word next to the mask gets an error and reads zero
      apb(1'b0, 32'hfff05018, 32'h0);
      check("unmapped data", rd, 32'h0);
      check("unmapped error", {31'h0, slv}, 32'h1);
      $display("test mask access done");
      // Each source: blocked while disabled, latched, then gated by master
      foreach (src[i]) begin
         apb(1'b1, UHIE_ADDR_CLEAR, 32'hffffffff);
         apb(1'b1, UHIE_ADDR_SET, 32'h80000000);
         event_in <= 32'h1 << src[i];
         @(posedge pclk);
         event_in <= 32'h0;
         repeat (2) @(posedge pclk);
         irq_is(1'b0);
         apb(1'b0, UHIE_ADDR_FLAGS, 32'h0);
         check("flags", rd, 32'h1 << src[i]);
         apb(1'b1, UHIE_ADDR_SET, 32'h1 << src[i]);
         irq_is(1'b1);
         apb(1'b1, UHIE_ADDR_CLEAR, 32'h80000000);
         irq_is(1'b0);
         apb(1'b1, UHIE_ADDR_FLAGS, 32'h1 << src[i]);
      end
      $display("test sources done");
      test_done();
   end

   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #20000;
      err_total++;
      test_done();
   end
endmodule : usb_host_irq_enable_mask_bench
